// >>> src/acdc_device.sv
`timescale 1ns/1ns
module acdc_device (
	input wire logic sys_clk, // oscillator stand-in
	input wire logic sys_rst, // async, active high
	acdc_link_if.dev lnk, // host side
	input wire logic mod_bit, // modulator bit stream
	input wire logic mod_sat, // modulator overload level
	output logic sys_tick, // divided system clock tick
	output logic mod_tick // modulator clock tick
);
	typedef logic signed [23:0] acdc_smp_type;
	// ----------------------------------------
	// registers
	// ----------------------------------------
	logic [7:0] cfg3_r, flt1_r, flt2_r, coef_lo_r, coef_idx_r;
	logic [15:0] coef_r [acdc_pkg::COEF_N];
	logic [acdc_pkg::COEF_N-1:0] coef_user_r;
	logic [2:0] s1_r, s2_r, s3_r, pin_r;
	logic [11:0] settle_r;
	logic [3:0] div_cnt_r;
	logic mod_ph_r, run_r, sat_acc_r, sat_flag_r;
	logic [12:0] osr_cnt_r, ones_r;
	acdc_smp_type iir_r [4];
	logic [23:0] data_r;
	logic rdy_r, rvalid_r;
	logic [7:0] rdata_r;
	logic pins_ok, pin_rst, soft_rst, ext_tick, src_tick, ll_forced, conv_done;
	logic [1:0] eff_spd;
	logic [4:0] div_ratio;
	logic [9:0] sinc_ratio;
	logic [12:0] osr, ones_nxt;
	logic [15:0] coef_eff [acdc_pkg::COEF_N];
	acdc_smp_type raw, st_a, st_b;
	acdc_smp_type iir_a [5];
	acdc_smp_type iir_b [5];

	function automatic acdc_smp_type fir_f(acdc_smp_type x, logic [15:0] g);
		logic signed [40:0] p;
		p = x * $signed({1'b0, g});
		return p[31:8];
	endfunction

	// one first-order section of the IIR cascade
	function automatic acdc_smp_type iir_f(acdc_smp_type x, acdc_smp_type y, logic [15:0] a);
		logic signed [24:0] d;
		logic signed [41:0] p;
		d = {x[23], x} - {y[23], y};
		p = d * $signed({1'b0, a});
		return y + p[31:8];
	endfunction

	// ----------------------------------------
	// pin synchronisers (3 stages, 2nd/3rd agree)
	// ----------------------------------------
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			s1_r <= 3'h4;
			s2_r <= 3'h4;
			s3_r <= 3'h4;
			pin_r <= 3'h4;
		end else begin
			s1_r <= {lnk.rst_pin_n, lnk.start_pin, lnk.ext_clk};
			s2_r <= s1_r;
			s3_r <= s2_r;
			for (int i = 0; i < 3; i++) begin
				if (s2_r[i] == s3_r[i]) begin
					pin_r[i] <= s3_r[i];
				end
			end
		end
	end

	assign ext_tick = s2_r[0] & s3_r[0] & ~pin_r[0];
	assign pins_ok = (settle_r == 12'h000);
	assign pin_rst = pins_ok & ~pin_r[2]; // [R9]
	assign soft_rst = pin_rst;

	// ----------------------------------------
	// clock source, divider, modulator phase
	// ----------------------------------------
	assign src_tick = cfg3_r[acdc_pkg::CFG3_SEL] ? ext_tick : 1'b1; // [R1] [R6]
	always_comb begin
		case (cfg3_r[acdc_pkg::CFG3_DIV +: 2]) // [R21]
			acdc_pkg::DIV_2: div_ratio = 5'h02;
			acdc_pkg::DIV_8: div_ratio = 5'h08;
			acdc_pkg::DIV_16: div_ratio = 5'h10;
			default: div_ratio = 5'h01;
		endcase
	end
	assign sys_tick = src_tick & ({1'b0, div_cnt_r} == div_ratio - 5'h01); // [R2]
	assign mod_tick = sys_tick & mod_ph_r; // [R2]

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			div_cnt_r <= 4'h0;
			mod_ph_r <= 1'b0;
		end else if (sys_tick) begin
			div_cnt_r <= 4'h0;
			mod_ph_r <= ~mod_ph_r;
		end else if (src_tick) begin
			div_cnt_r <= div_cnt_r + 4'h1;
		end
	end

	// effective speed mode reads as mid on div-2/div-16
	assign ll_forced = (cfg3_r[acdc_pkg::CFG3_DIV +: 2] == acdc_pkg::DIV_2) |
		(cfg3_r[acdc_pkg::CFG3_DIV +: 2] == acdc_pkg::DIV_16);
	assign eff_spd = ll_forced ? acdc_pkg::SPD_MID : cfg3_r[acdc_pkg::CFG3_SPD +: 2]; // [R3]

	// ----------------------------------------
	// register writes
	// ----------------------------------------
	// settle window: pins stay masked after a clock source change
	// a soft reset that drops the pin clock is a source change too
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			settle_r <= 12'h000;
		end else if (soft_rst ? cfg3_r[acdc_pkg::CFG3_SEL] : (lnk.reg_wr && lnk.reg_addr == acdc_pkg::ADDR_CFG3 &&
			lnk.reg_wdata[acdc_pkg::CFG3_SEL] != cfg3_r[acdc_pkg::CFG3_SEL])) begin
			settle_r <= 12'(acdc_pkg::SETTLE_CYC); // [R9]
		end else if (!pins_ok) begin
			settle_r <= settle_r - 12'h001;
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			cfg3_r <= acdc_pkg::CFG3_RST; // [R5]
			flt1_r <= acdc_pkg::FLT1_RST;
			flt2_r <= acdc_pkg::FLT2_RST;
			coef_idx_r <= 8'h00;
			coef_lo_r <= 8'h00;
			coef_user_r <= '0;
		end else if (soft_rst) begin
			cfg3_r <= acdc_pkg::CFG3_RST; // [R5]
			flt1_r <= acdc_pkg::FLT1_RST;
			flt2_r <= acdc_pkg::FLT2_RST;
			coef_idx_r <= 8'h00;
			coef_lo_r <= 8'h00;
			coef_user_r <= '0;
		end else if (lnk.reg_wr) begin
			case (lnk.reg_addr)
				acdc_pkg::ADDR_CFG3: cfg3_r <= {3'h0, lnk.reg_wdata[4:0]};
				acdc_pkg::ADDR_FLT1: flt1_r <= {3'h0, lnk.reg_wdata[4:0]}; // [R19]
				acdc_pkg::ADDR_FLT2: flt2_r <= {3'h0, lnk.reg_wdata[4:0]};
				acdc_pkg::ADDR_COEF_IDX: coef_idx_r <= lnk.reg_wdata;
				acdc_pkg::ADDR_COEF_LO: coef_lo_r <= lnk.reg_wdata;
				acdc_pkg::ADDR_COEF_HI: begin
					if (coef_idx_r < 8'(acdc_pkg::COEF_N)) begin
						coef_user_r[coef_idx_r[2:0]] <= 1'b1; // [R15]
					end
				end
				default: ;
			endcase
		end
	end

	// coefficient store; no reset needed, the user mask guards it
	always_ff @(posedge sys_clk) begin
		if (lnk.reg_wr && lnk.reg_addr == acdc_pkg::ADDR_COEF_HI &&
			coef_idx_r < 8'(acdc_pkg::COEF_N)) begin
			coef_r[coef_idx_r[2:0]] <= {lnk.reg_wdata, coef_lo_r}; // [R15]
		end
	end

	always_comb begin
		for (int i = 0; i < acdc_pkg::COEF_N; i++) begin
			coef_eff[i] = coef_user_r[i] ? coef_r[i] : acdc_pkg::COEF_DEFAULT; // [R15]
		end
	end

	// ----------------------------------------
	// register reads, one cycle later
	// ----------------------------------------
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			rdata_r <= 8'h00;
			rvalid_r <= 1'b0;
		end else begin
			rvalid_r <= lnk.reg_rd;
			case (lnk.reg_addr)
				acdc_pkg::ADDR_STATUS_REGISTER_ONE: rdata_r <= {3'h0, ll_forced, ~pins_ok, eff_spd, sat_flag_r};
				acdc_pkg::ADDR_CFG3: rdata_r <= cfg3_r;
				acdc_pkg::ADDR_FLT1: rdata_r <= flt1_r;
				acdc_pkg::ADDR_FLT2: rdata_r <= flt2_r;
				acdc_pkg::ADDR_COEF_IDX: rdata_r <= coef_idx_r;
				acdc_pkg::ADDR_COEF_LO: rdata_r <= coef_lo_r;
				default: rdata_r <= 8'h00;
			endcase
		end
	end

	// ----------------------------------------
	// conversion: sinc count, decimation, filters
	// ----------------------------------------
	// codes above 7 clamp to the largest sinc ratio
	assign sinc_ratio = (flt1_r[4:3] != 2'h0) ? 10'h200 : 10'(10'h004 << flt1_r[2:0]); // [R19]
	always_comb begin
		if (flt2_r[acdc_pkg::FLT2_LL]) begin
			osr = {3'h0, sinc_ratio}; // [R14]
		end else begin
			// compensation and halfband each halve; disabled ones do not [R20] [R17]
			osr = {3'h0, sinc_ratio} << (2'h1 + {1'b0, flt2_r[acdc_pkg::FLT2_HB]} +
				{1'b0, flt2_r[acdc_pkg::FLT2_FF]});
		end
	end

	// >= so a smaller ratio written mid-count ends the word instead of wrapping
	assign conv_done = run_r & mod_tick & (osr_cnt_r >= osr - 13'h0001); // [R13]
	assign ones_nxt = ones_r + {12'h000, mod_bit};
	assign raw = {10'h000, ones_nxt, 1'b0} - {11'h000, osr};

	// swap picks which of final FIR / IIR sees the raw word first
	always_comb begin
		iir_a[0] = raw;
		for (int k = 0; k < 4; k++) begin
			iir_a[k + 1] = iir_f(iir_a[k], iir_r[k], coef_eff[k + 1]); // [R14]
		end
		st_a = flt2_r[acdc_pkg::FLT2_SWAP] ? (flt2_r[acdc_pkg::FLT2_IIR] ? iir_a[4] : raw) :
			(flt2_r[acdc_pkg::FLT2_FF] ? fir_f(raw, coef_eff[0]) : raw); // [R16] [R17]
		iir_b[0] = st_a;
		for (int k = 0; k < 4; k++) begin
			iir_b[k + 1] = iir_f(iir_b[k], iir_r[k], coef_eff[k + 1]);
		end
		st_b = flt2_r[acdc_pkg::FLT2_SWAP] ? (flt2_r[acdc_pkg::FLT2_FF] ? fir_f(st_a, coef_eff[0]) : st_a) :
			(flt2_r[acdc_pkg::FLT2_IIR] ? iir_b[4] : st_a); // [R16] [R17]
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			run_r <= 1'b0;
			osr_cnt_r <= 13'h0000;
			ones_r <= 13'h0000;
			sat_acc_r <= 1'b0;
			sat_flag_r <= 1'b0;
			data_r <= 24'h000000;
			rdy_r <= 1'b0;
			for (int k = 0; k < 4; k++) begin
				iir_r[k] <= 24'sh000000;
			end
		end else begin
			rdy_r <= conv_done;
			if (pins_ok) begin
				run_r <= pin_r[1]; // [R9]
			end
			if (!run_r || soft_rst) begin
				osr_cnt_r <= 13'h0000;
				ones_r <= 13'h0000;
				sat_acc_r <= 1'b0;
			end else if (conv_done) begin
				osr_cnt_r <= 13'h0000;
				ones_r <= 13'h0000;
				sat_acc_r <= 1'b0;
				sat_flag_r <= sat_acc_r | mod_sat; // [R12]
				data_r <= flt2_r[acdc_pkg::FLT2_LL] ? raw : st_b;
				for (int k = 0; k < 4; k++) begin
					iir_r[k] <= flt2_r[acdc_pkg::FLT2_SWAP] ? iir_a[k + 1] : iir_b[k + 1];
				end
			end else if (mod_tick) begin
				osr_cnt_r <= osr_cnt_r + 13'h0001;
				ones_r <= ones_nxt;
				sat_acc_r <= sat_acc_r | mod_sat; // [R12]
			end
		end
	end

	assign lnk.reg_rdata = rdata_r;
	assign lnk.reg_rvalid = rvalid_r;
	assign lnk.data_word = data_r;
	assign lnk.data_rdy = rdy_r;
endmodule // acdc_device

// >>> src/acdc_pkg.sv
// Notes on behaviour
// [R1] clock from pin or oscillator, chosen by select
// [R2] system clock from divider, modulator clock half
// [R3] div-2/div-16 force low-latency mode to mid
// [R4] host supplies nominal clock per speed mode
// [R5] after reset select reads zero, oscillator runs
// [R6] oscillator fixed; slow modes need divider
// [R7] host never selects oscillator in max speed
// [R8] host keeps pin clock four cycles after switch
// [R9] start/reset pins ignored 150 us after switch
// [R10] host starts pin clock before selecting it
// [R11] host uses divide-by-one when syncing externally; acdc_host forwards whatever divider the command writes
// [R12] saturation latched per conversion, refreshed at end
// [R13] word rate is modulator clock over OSR
// [R14] wideband and low-latency modes; four IIR sections
// [R15] user coefficients; defaults until programmed
// [R16] final FIR and IIR order swappable
// [R17] disabled stage bypasses filter and decimation
// [R18] halfband off forces final FIR, IIR off
// [R19] sinc ratio 4 to 512 via five-bit field
// [R20] compensation and halfband each decimate by two
// [R21] divider offers 1, 2, 8 and 16
package acdc_pkg;
	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int SYS_CLK_HZ = 25_000_000;
	localparam int SETTLE_NS = 150_000;
	// least time, rounded up to whole cycles
	localparam int SETTLE_CYC = (SETTLE_NS * (SYS_CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int KEEP_EXT_CYC = 4;
	localparam int NOM_MAX_HZ = 32_768_000;
	localparam int NOM_HIGH_HZ = 25_600_000;
	localparam int NOM_MID_HZ = 12_800_000;
	localparam int NOM_LOW_HZ = 3_200_000;
	localparam int OSC_HZ = 25_600_000;
	// ----------------------------------------
	// register map
	// ----------------------------------------
	localparam logic [3:0] ADDR_STATUS_REGISTER_ONE = 4'h0;
	localparam logic [3:0] ADDR_CFG3 = 4'h1;
	localparam logic [3:0] ADDR_FLT1 = 4'h2;
	localparam logic [3:0] ADDR_FLT2 = 4'h3;
	localparam logic [3:0] ADDR_COEF_IDX = 4'h4;
	localparam logic [3:0] ADDR_COEF_LO = 4'h5;
	localparam logic [3:0] ADDR_COEF_HI = 4'h6;
	localparam int CFG3_SEL = 0;
	localparam int CFG3_DIV = 1;
	localparam int CFG3_SPD = 3;
	localparam int FLT2_HB = 0;
	localparam int FLT2_FF = 1;
	localparam int FLT2_IIR = 2;
	localparam int FLT2_SWAP = 3;
	localparam int FLT2_LL = 4;
	localparam logic [7:0] CFG3_RST = 8'h00;
	localparam logic [7:0] FLT1_RST = 8'h00;
	localparam logic [7:0] FLT2_RST = 8'h07;
	localparam logic [1:0] DIV_1 = 2'h0;
	localparam logic [1:0] DIV_2 = 2'h1;
	localparam logic [1:0] DIV_8 = 2'h2;
	localparam logic [1:0] DIV_16 = 2'h3;
	localparam logic [1:0] SPD_LOW = 2'h0;
	localparam logic [1:0] SPD_MID = 2'h1;
	localparam logic [1:0] SPD_HIGH = 2'h2;
	localparam logic [1:0] SPD_MAX = 2'h3;
	localparam logic [15:0] COEF_DEFAULT = 16'h0100;
	localparam int COEF_N = 5;
endpackage

// >>> src/acdc_link_if.sv
`timescale 1ns/1ns
// host and converter meet here; pins are one-way
interface acdc_link_if;
	logic reg_wr;
	logic reg_rd;
	logic [3:0] reg_addr;
	logic [7:0] reg_wdata;
	logic [7:0] reg_rdata;
	logic reg_rvalid;
	logic ext_clk;
	logic start_pin;
	logic rst_pin_n;
	logic [23:0] data_word;
	logic data_rdy;
	modport dev (input reg_wr, reg_rd, reg_addr, reg_wdata, ext_clk, start_pin, rst_pin_n,
		output reg_rdata, reg_rvalid, data_word, data_rdy);
	modport host (output reg_wr, reg_rd, reg_addr, reg_wdata, ext_clk, start_pin, rst_pin_n,
		input reg_rdata, reg_rvalid, data_word, data_rdy);
endinterface

// >>> src/acdc_host.sv
`timescale 1ns/1ns
module acdc_host #(
	parameter int EXT_HALF = 1, // sys_clk cycles per ext clock half period
	parameter int LEAD_CYC = 4 // ext clock cycles before selecting pin clock
) (
	input wire logic sys_clk, // system clock
	input wire logic sys_rst, // async, active high
	acdc_link_if.host lnk, // converter side
	input wire logic cmd_wr, // write request
	input wire logic cmd_rd, // read request
	input wire logic [3:0] cmd_addr, // register address
	input wire logic [7:0] cmd_wdata, // write data
	output logic cmd_busy, // request not taken
	output logic cmd_refused, // write refused pulse
	output logic [7:0] cmd_rdata, // read data
	output logic cmd_rvalid, // read data pulse
	input wire logic user_start, // run conversions
	input wire logic user_rst, // pulse converter reset pin
	output logic [23:0] data_out, // last word
	output logic data_valid // new word pulse
);
	typedef enum {ST_IDLE, ST_LEAD, ST_HOLD} acdc_hst_type;
	acdc_hst_type st_r;
	logic [7:0] ext_div_r;
	logic ext_clk_r, ext_run_r, sel_r, wr_r, rd_r, refused_r, rvalid_r, valid_r;
	logic [3:0] addr_r;
	logic [7:0] wdata_r, pend_r, rdata_r;
	logic [3:0] edge_cnt_r;
	logic [23:0] data_r;
	logic ext_rise, bad_osc, to_ext, to_osc;

	assign ext_rise = ext_run_r & ~ext_clk_r & (ext_div_r == 8'(EXT_HALF - 1));
	assign bad_osc = cmd_wr & (cmd_addr == acdc_pkg::ADDR_CFG3) & ~cmd_wdata[acdc_pkg::CFG3_SEL] &
		(cmd_wdata[acdc_pkg::CFG3_SPD +: 2] == acdc_pkg::SPD_MAX); // [R7]
	assign to_ext = cmd_wr & (cmd_addr == acdc_pkg::ADDR_CFG3) & cmd_wdata[acdc_pkg::CFG3_SEL] & ~sel_r;
	assign to_osc = cmd_wr & (cmd_addr == acdc_pkg::ADDR_CFG3) & ~cmd_wdata[acdc_pkg::CFG3_SEL] & sel_r;
	assign cmd_busy = (st_r != ST_IDLE);

	// ----------------------------------------
	// pin clock generator
	// ----------------------------------------
	// rate set by EXT_HALF, pick it for the nominal speed-mode clock [R4]
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ext_div_r <= 8'h00;
			ext_clk_r <= 1'b0;
		end else if (!ext_run_r) begin
			ext_div_r <= 8'h00;
			ext_clk_r <= 1'b0;
		end else if (ext_div_r == 8'(EXT_HALF - 1)) begin
			ext_div_r <= 8'h00;
			ext_clk_r <= ~ext_clk_r;
		end else begin
			ext_div_r <= ext_div_r + 8'h01;
		end
	end

	// ----------------------------------------
	// command sequencer
	// ----------------------------------------
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			st_r <= ST_IDLE;
			ext_run_r <= 1'b0;
			sel_r <= 1'b0;
			wr_r <= 1'b0;
			rd_r <= 1'b0;
			addr_r <= 4'h0;
			wdata_r <= 8'h00;
			pend_r <= 8'h00;
			edge_cnt_r <= 4'h0;
			refused_r <= 1'b0;
		end else begin
			wr_r <= 1'b0;
			rd_r <= 1'b0;
			refused_r <= 1'b0;
			case (st_r)
				ST_IDLE: begin
					edge_cnt_r <= 4'h0;
					if (bad_osc) begin
						refused_r <= 1'b1; // [R7]
					end else if (to_ext) begin
						ext_run_r <= 1'b1; // [R10]
						pend_r <= cmd_wdata;
						st_r <= ST_LEAD;
					end else if (cmd_wr) begin
						wr_r <= 1'b1;
						addr_r <= cmd_addr;
						wdata_r <= cmd_wdata;
						if (cmd_addr == acdc_pkg::ADDR_FLT2 && !cmd_wdata[acdc_pkg::FLT2_HB]) begin
							wdata_r[acdc_pkg::FLT2_FF] <= 1'b0; // [R18]
							wdata_r[acdc_pkg::FLT2_IIR] <= 1'b0; // [R18]
						end
						if (to_osc) begin
							sel_r <= 1'b0;
							st_r <= ST_HOLD; // [R8]
						end
					end else if (cmd_rd) begin
						rd_r <= 1'b1;
						addr_r <= cmd_addr;
					end
				end
				ST_LEAD: begin
					if (ext_rise) begin
						edge_cnt_r <= edge_cnt_r + 4'h1;
					end
					if (edge_cnt_r == 4'(LEAD_CYC)) begin
						wr_r <= 1'b1; // [R10]
						addr_r <= acdc_pkg::ADDR_CFG3;
						wdata_r <= pend_r;
						sel_r <= 1'b1;
						st_r <= ST_IDLE;
					end
				end
				ST_HOLD: begin
					if (ext_rise) begin
						edge_cnt_r <= edge_cnt_r + 4'h1;
					end
					if (edge_cnt_r == 4'(acdc_pkg::KEEP_EXT_CYC)) begin
						ext_run_r <= 1'b0; // [R8]
						st_r <= ST_IDLE;
					end
				end
				default: st_r <= ST_IDLE;
			endcase
		end
	end

	// answers and conversion words
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			rdata_r <= 8'h00;
			rvalid_r <= 1'b0;
			data_r <= 24'h000000;
			valid_r <= 1'b0;
		end else begin
			rvalid_r <= lnk.reg_rvalid;
			valid_r <= lnk.data_rdy;
			if (lnk.reg_rvalid) begin
				rdata_r <= lnk.reg_rdata;
			end
			if (lnk.data_rdy) begin
				data_r <= lnk.data_word;
			end
		end
	end

	assign lnk.reg_wr = wr_r;
	assign lnk.reg_rd = rd_r;
	assign lnk.reg_addr = addr_r;
	assign lnk.reg_wdata = wdata_r;
	assign lnk.ext_clk = ext_clk_r;
	assign lnk.start_pin = user_start;
	assign lnk.rst_pin_n = ~user_rst;
	assign cmd_refused = refused_r;
	assign cmd_rdata = rdata_r;
	assign cmd_rvalid = rvalid_r;
	assign data_out = data_r;
	assign data_valid = valid_r;
endmodule // acdc_host

// >>> testbench/acdc_link_monitor.sv
`timescale 1ns/1ns
// ----------------------------------------
// link checker
// ----------------------------------------
module acdc_link_monitor (
	input wire logic sys_clk, // system clock
	input wire logic sys_rst, // async, active high
	input wire logic reg_wr, // write strobe
	input wire logic reg_rd, // read strobe
	input wire logic [3:0] reg_addr, // register address
	input wire logic [7:0] reg_wdata, // write data
	input wire logic reg_rvalid, // read answer
	input wire logic ext_clk, // pin clock
	input wire logic data_rdy // word strobe
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (sys_rst);

	logic cb_last1;
	logic cb_last2;
	// strobes that touch the clock setup register
	wire logic cfg_wr = reg_wr && reg_addr == acdc_pkg::ADDR_CFG3;
	// pin clock seen moving over the last two cycles; bench runs it at four cycles a period
	wire logic ext_live = ext_clk != cb_last1 || cb_last1 != cb_last2;

	// history of the pin clock for the liveness test
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			cb_last1 <= 1'b0;
			cb_last2 <= 1'b0;
		end else begin
			cb_last1 <= ext_clk;
			cb_last2 <= cb_last1;
		end
	end

	property p_rd_answer;
		reg_rd |=> reg_rvalid;
	endproperty
	a_rd_answer: assert property (p_rd_answer) else $error("read strobe without answer");

	property p_rvalid_cause;
		reg_rvalid |-> $past(reg_rd);
	endproperty
	a_rvalid_cause: assert property (p_rvalid_cause) else $error("answer without read");

	property p_one_strobe;
		!(reg_wr && reg_rd);
	endproperty
	a_one_strobe: assert property (p_one_strobe) else $error("read and write together");

	property p_lead_clock;
		cfg_wr && reg_wdata[0] |-> ext_live;
	endproperty
	a_lead_clock: assert property (p_lead_clock) else $error("pin clock selected while still");

	// four rising edges must follow a switch back while the pin clock runs
	property p_keep_clock;
		cfg_wr && !reg_wdata[0] && ext_live |-> ##[1:4] $rose(ext_clk) ##[1:4] $rose(ext_clk)
			##[1:4] $rose(ext_clk) ##[1:4] $rose(ext_clk);
	endproperty
	a_keep_clock: assert property (p_keep_clock) else $error("pin clock stopped early");

	property p_no_max_osc;
		cfg_wr |-> reg_wdata[0] || reg_wdata[4:3] != acdc_pkg::SPD_MAX;
	endproperty
	a_no_max_osc: assert property (p_no_max_osc) else $error("oscillator sent with max speed");

	property p_halfband_chain;
		reg_wr && reg_addr == acdc_pkg::ADDR_FLT2 && !reg_wdata[0] |-> reg_wdata[2:1] == 2'h0;
	endproperty
	a_halfband_chain: assert property (p_halfband_chain) else $error("later stages left on");

	// shortest conversion is four modulator ticks, eight cycles
	property p_word_spacing;
		data_rdy |=> !data_rdy [*7];
	endproperty
	a_word_spacing: assert property (p_word_spacing) else $error("words too close");
endmodule // acdc_link_monitor

// >>> testbench/testbench.sv
`timescale 1ns/1ns
`define CHK(g, e) \
	begin \
		comparisons++; \
		if ((g) !== (e)) begin \
			n_errors++; \
			$display("BAD t=%0t got %h exp %h", $time, g, e); \
		end \
	end

module testbench;
	typedef struct {logic [3:0] a; logic [7:0] d; logic [3:0] ra; logic [7:0] e;} acdc_rrow_type;
	typedef struct {logic [7:0] c3; logic [7:0] f1; logic [7:0] f2; int per; logic [23:0] dat;} acdc_crow_type;
	logic sys_clk, sys_rst, cmd_wr, cmd_rd, user_start, user_rst, mod_bit, mod_sat;
	logic cmd_busy, cmd_rvalid, data_valid, cmd_refused, sys_tick, mod_tick;
	logic [3:0] cmd_addr;
	logic [7:0] cmd_wdata, cmd_rdata, rdv;
	logic [23:0] data_out;
	int n_errors = 0;
	int comparisons = 0;
	int n;
	int n2;
	int n_refused = 0;
	int n_sys = 0;
	int n_mod = 0;
	// write, then read back; status rows show the effective speed, forced to mid on div-2/div-16
	acdc_rrow_type rrows[9] = '{
		'{4'h1, 8'h06, 4'h1, 8'h06},
		'{4'h1, 8'h1a, 4'h1, 8'h06},
		'{4'h1, 8'h02, 4'h0, 8'h12},
		'{4'h1, 8'h16, 4'h0, 8'h12},
		'{4'h1, 8'h04, 4'h0, 8'h00},
		'{4'h1, 8'h10, 4'h0, 8'h04},
		'{4'h2, 8'hff, 4'h2, 8'h1f},
		'{4'h3, 8'h0e, 4'h3, 8'h08},
		'{4'hf, 8'h55, 4'hf, 8'h00}};
	// all-ones modulator: word equals the overall ratio
	acdc_crow_type crows[10] = '{
		'{8'h00, 8'h00, 8'h10, 8, 24'h4},
		'{8'h00, 8'h01, 8'h10, 16, 24'h8},
		'{8'h00, 8'h08, 8'h10, 1024, 24'h200},
		'{8'h02, 8'h00, 8'h10, 16, 24'h4},
		'{8'h04, 8'h00, 8'h10, 64, 24'h4},
		'{8'h06, 8'h00, 8'h10, 128, 24'h4},
		'{8'h00, 8'h00, 8'h00, 16, 24'h8},
		'{8'h00, 8'h00, 8'h01, 32, 24'h10},
		'{8'h00, 8'h00, 8'h07, 64, 24'h20},
		'{8'h00, 8'h00, 8'h0f, 64, 24'h20}};

	acdc_link_if lnk();
	acdc_device u_acdc_device (.sys_clk(sys_clk), .sys_rst(sys_rst), .lnk(lnk), .mod_bit(mod_bit),
		.mod_sat(mod_sat), .sys_tick(sys_tick), .mod_tick(mod_tick));
	// pin clock must be slow enough for the three-flop filter to see both levels
	acdc_host #(.EXT_HALF(2), .LEAD_CYC(4)) u_acdc_host (.sys_clk(sys_clk), .sys_rst(sys_rst), .lnk(lnk),
		.cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_busy(cmd_busy),
		.cmd_refused(cmd_refused), .cmd_rdata(cmd_rdata), .cmd_rvalid(cmd_rvalid), .user_start(user_start),
		.user_rst(user_rst), .data_out(data_out), .data_valid(data_valid));
	acdc_link_monitor u_acdc_link_monitor (.sys_clk(sys_clk), .sys_rst(sys_rst), .reg_wr(lnk.reg_wr),
		.reg_rd(lnk.reg_rd), .reg_addr(lnk.reg_addr), .reg_wdata(lnk.reg_wdata), .reg_rvalid(lnk.reg_rvalid),
		.ext_clk(lnk.ext_clk), .data_rdy(lnk.data_rdy));

	// 25 MHz system clock
	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end

	// running counts of refusals and clock ticks
	always @(posedge sys_clk) begin
		if (cmd_refused === 1'b1) n_refused++;
		if (sys_tick === 1'b1) n_sys++;
		if (mod_tick === 1'b1) n_mod++;
	end

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task results;
		$display("comparisons %0d mismatches %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task timeout;
		n_errors++;
		$display("BAD t=%0t wait ran out", $time);
		results();
	endtask

	// a clock switch keeps the host busy for a few cycles only
	task automatic idle;
		int i;
		for (i = 0; i < 100 && cmd_busy !== 1'b0; i++) @(negedge sys_clk);
		if (i == 100) timeout();
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		idle();
		cmd_wr = 1'b1;
		cmd_addr = a;
		cmd_wdata = d;
		@(negedge sys_clk);
		cmd_wr = 1'b0;
		@(negedge sys_clk);
		idle();
	endtask

	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		int i;
		idle();
		cmd_rd = 1'b1;
		cmd_addr = a;
		@(negedge sys_clk);
		cmd_rd = 1'b0;
		for (i = 0; i < 8 && cmd_rvalid !== 1'b1; i++) @(negedge sys_clk);
		if (i == 8) timeout();
		d = cmd_rdata;
	endtask

	// cycles since the previous word
	task automatic word(output int c);
		c = 0;
		do begin
			@(negedge sys_clk);
			c++;
		end while (data_valid !== 1'b1 && c < 3000);
		if (c == 3000) timeout();
	endtask

	// first two words may straddle the change, so the third is judged
	task automatic conv(input logic [7:0] c3, f1, f2, input int per, input logic [23:0] dat);
		wr(4'h1, c3);
		wr(4'h2, f1);
		wr(4'h3, f2);
		word(n);
		word(n);
		word(n);
		`CHK(n, per)
		`CHK(data_out, dat)
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		sys_rst = 1'b1;
		{cmd_wr, cmd_rd, user_start, user_rst, mod_sat} = 5'h00;
		cmd_addr = 4'h0;
		cmd_wdata = 8'h00;
		mod_bit = 1'b1;
		repeat (20) @(negedge sys_clk);
		sys_rst = 1'b0;
		foreach (rrows[k]) begin
			wr(rrows[k].a, rrows[k].d);
			rd(rrows[k].ra, rdv);
			`CHK(rdv, rrows[k].e)
		end
		`CHK(n_refused, 1)
		$display("test registers done");
		user_start = 1'b1;
		foreach (crows[k]) conv(crows[k].c3, crows[k].f1, crows[k].f2, crows[k].per, crows[k].dat);
		$display("test rates done");
		// flag follows the last whole conversion
		mod_sat = 1'b1;
		word(n);
		word(n);
		rd(4'h0, rdv);
		`CHK(rdv, 8'h01)
		mod_sat = 1'b0;
		word(n);
		word(n);
		rd(4'h0, rdv);
		`CHK(rdv, 8'h00)
		$display("test saturation done");
		wr(4'h4, 8'h00);
		wr(4'h5, 8'h00);
		wr(4'h6, 8'h02);
		conv(8'h00, 8'h00, 8'h03, 64, 24'h40);
		$display("test coefficient done");
		// reset pin pulsed inside the settle window must be ignored
		wr(4'h1, 8'h01);
		user_rst = 1'b1;
		repeat (10) @(negedge sys_clk);
		user_rst = 1'b0;
		rd(4'h1, rdv);
		`CHK(rdv, 8'h01)
		rd(4'h0, rdv);
		`CHK(rdv, 8'h08)
		repeat (acdc_pkg::SETTLE_CYC) @(negedge sys_clk);
		// pin clock ticks every fourth cycle, so each word takes four times as long
		conv(8'h01, 8'h00, 8'h10, 32, 24'h4);
		user_rst = 1'b1;
		repeat (10) @(negedge sys_clk);
		user_rst = 1'b0;
		rd(4'h1, rdv);
		`CHK(rdv, 8'h00)
		wr(4'h1, 8'h00);
		$display("test clock source done");
		sys_rst = 1'b1;
		repeat (20) @(negedge sys_clk);
		sys_rst = 1'b0;
		rd(4'h1, rdv);
		`CHK(rdv, 8'h00)
		rd(4'h2, rdv);
		`CHK(rdv, 8'h00)
		rd(4'h3, rdv);
		`CHK(rdv, 8'h07)
		$display("test reset done");
		// oscillator, divide by one: a tick each cycle, modulator half that
		n = n_sys;
		n2 = n_mod;
		repeat (64) @(negedge sys_clk);
		`CHK(n_sys - n, 64)
		`CHK(n_mod - n2, 32)
		$display("test ticks done");
		results();
	end
endmodule // testbench
